//--- agcr_regs.svh
// Register offsets, field positions, reset values and decode tables.
`ifndef AGCR_REGS_SVH
`define AGCR_REGS_SVH
`define AGCR_IDX_CTRL_A 8'h1d
`define AGCR_IDX_CTRL_B 8'h1e
`define AGCR_IDX_CTRL_C 8'h1f
`define AGCR_IDX_LGAIN 8'h20
`define AGCR_RST_CTRL_A 8'h00
`define AGCR_RST_CTRL_B 8'hfe
`define AGCR_RST_CTRL_C 8'h00
`define AGCR_RST_LGAIN 8'h00
`define AGCR_BIT_EN 7
`define AGCR_TGT_HI 6
`define AGCR_TGT_LO 4
`define AGCR_ATK_HI 3
`define AGCR_ATK_LO 2
`define AGCR_DCY_HI 1
`define AGCR_DCY_LO 0
`define AGCR_MAXG_HI 7
`define AGCR_MAXG_LO 1
`define AGCR_HYS_HI 7
`define AGCR_HYS_LO 6
`define AGCR_THR_HI 5
`define AGCR_THR_LO 1
`define AGCR_BIT_CLIP 0
`define AGCR_MAXG_CAP 7'h77
`define AGCR_GAIN_MIN 8'he8
`define AGCR_GAIN_MAX 8'h77
`define AGCR_ATK_MS0 16'd8
`define AGCR_ATK_MS1 16'd11
`define AGCR_ATK_MS2 16'd16
`define AGCR_ATK_MS3 16'd20
`define AGCR_DCY_MS0 16'd100
`define AGCR_DCY_MS1 16'd200
`define AGCR_DCY_MS2 16'd400
`define AGCR_DCY_MS3 16'd500
`define AGCR_THR_BASE 8'd30
`define AGCR_THR_STEP 8'd2
`endif

//--- agcr_pkg.sv
// Types shared by the gain control register bank.
package agcr_pkg;
	typedef enum logic [1:0] {
		AGCR_HYS_1DB,
		AGCR_HYS_2DB,
		AGCR_HYS_4DB,
		AGCR_HYS_OFF
	} agcr_hys_t;
	typedef struct packed {
		logic enable;
		logic [2:0] target;
		logic [1:0] attack;
		logic [1:0] decay;
		logic [6:0] max_gain;
		logic [1:0] hyst;
		logic [4:0] noise_thr;
		logic clip_step;
	} agcr_cfg_t;
endpackage

//--- agcr_cfg_if.sv
// Raw configuration fields passed from the register file to the decoder.
`timescale 1ns/100ps
interface agcr_cfg_if;
	import agcr_pkg::*;
	agcr_cfg_t cfg;
	modport src (output cfg);
	modport dst (input cfg);
endinterface

//--- agcr_decode.sv
// Decoder turning raw configuration codes into working values.
`timescale 1ns/100ps
`include "agcr_regs.svh"
module agcr_decode
	import agcr_pkg::*;
(
	input wire logic hclk, // Core clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	agcr_cfg_if.dst cfg_in, // Raw configuration codes.
	output logic agc_on, // Gain control enabled.
	output logic [2:0] target_code, // Loudness target code.
	output logic [15:0] attack_ms, // Attack time in ms.
	output logic [15:0] decay_ms, // Decay time in ms.
	output logic [6:0] max_gain_half_db, // Gain cap in 0.5 dB.
	output logic hyst_on, // Hysteresis active.
	output logic [2:0] hyst_db, // Hysteresis in dB.
	output logic noise_det_on, // Noise detection active.
	output logic [7:0] noise_thr_neg_db, // Threshold magnitude.
	output logic clip_step_on // Clip stepping active.
);
	typedef struct packed {
		logic on;
		logic [2:0] tgt;
		logic [15:0] atk;
		logic [15:0] dcy;
		logic [6:0] maxg;
		logic hon;
		logic [2:0] hdb;
		logic non;
		logic [7:0] thr;
		logic clip;
	} agcr_dec_t;
	agcr_dec_t st_q, st_d;
	agcr_cfg_t c;
	assign c = cfg_in.cfg;
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.on = c.enable; // see RQ1
		st_d.tgt = c.target; // see RQ2
		// Times hold only without double-rate operation. see RQ5
		case (c.attack) // see RQ3
			2'h0: st_d.atk = `AGCR_ATK_MS0;
			2'h1: st_d.atk = `AGCR_ATK_MS1;
			2'h2: st_d.atk = `AGCR_ATK_MS2;
			default: st_d.atk = `AGCR_ATK_MS3;
		endcase
		case (c.decay) // see RQ4
			2'h0: st_d.dcy = `AGCR_DCY_MS0;
			2'h1: st_d.dcy = `AGCR_DCY_MS1;
			2'h2: st_d.dcy = `AGCR_DCY_MS2;
			default: st_d.dcy = `AGCR_DCY_MS3;
		endcase
		// Codes above the cap saturate to 59.5 dB. see RQ6
		if (c.max_gain > `AGCR_MAXG_CAP) begin
			st_d.maxg = `AGCR_MAXG_CAP;
		end else begin
			st_d.maxg = c.max_gain;
		end
		st_d.hon = 1'b1;
		case (agcr_hys_t'(c.hyst)) // see RQ8
			AGCR_HYS_1DB: st_d.hdb = 3'h1;
			AGCR_HYS_2DB: st_d.hdb = 3'h2;
			AGCR_HYS_4DB: st_d.hdb = 3'h4;
			default: begin
				st_d.hdb = 3'h0;
				st_d.hon = 1'b0;
			end
		endcase
		st_d.non = (c.noise_thr != 5'h00); // see RQ9
		if (st_d.non) begin
			st_d.thr = 8'(`AGCR_THR_BASE + `AGCR_THR_STEP *
				{3'h0, c.noise_thr - 5'h01});
		end else begin
			st_d.thr = 8'h00;
		end
		st_d.clip = c.clip_step; // see RQ10
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign agc_on = st_q.on;
	assign target_code = st_q.tgt;
	assign attack_ms = st_q.atk;
	assign decay_ms = st_q.dcy;
	assign max_gain_half_db = st_q.maxg;
	assign hyst_on = st_q.hon;
	assign hyst_db = st_q.hdb;
	assign noise_det_on = st_q.non;
	assign noise_thr_neg_db = st_q.thr;
	assign clip_step_on = st_q.clip;
endmodule

//--- agcr_top.sv
// AHB-Lite register bank for right-channel gain control settings.
//
// Overview of operation
// RQ1 - Top bit of control register A enables the right gain control.
// RQ2 - Three-bit target code selects loudness target, -5.5 dB to -24 dB.
// RQ3 - Two-bit attack code selects 8, 11, 16 or 20 ms.
// RQ4 - Two-bit decay code selects 100, 200, 400 or 500 ms.
// RQ5 - Attack and decay times hold only with double-rate operation off.
// RQ6 - Seven-bit gain cap in 0.5 dB steps, saturating at 59.5 dB.
// RQ7 - Software writes zero to the reserved low bit of register B.
// RQ8 - Hysteresis code gives 1, 2 or 4 dB; code 3 turns it off.
// RQ9 - Noise threshold zero disables detection; else -30 dB down 2 dB/step.
// RQ10 - Low bit of register C enables clip stepping.
// RQ11 - Left applied gain is read back as signed 0.5 dB value.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "agcr_regs.svh"
module agcr_top
	import agcr_pkg::*;
(
	input wire logic hclk, // Core clock, 10 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready in.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Response, always OKAY.
	input wire logic [7:0] left_gain_in, // Left gain from the algorithm.
	input wire logic dbl_rate_on, // Double-rate audio operation active.
	output logic agc_on, // Gain control enabled.
	output logic [2:0] target_code, // Loudness target code.
	output logic [15:0] attack_ms, // Attack time in ms.
	output logic [15:0] decay_ms, // Decay time in ms.
	output logic times_valid, // Attack and decay figures exact.
	output logic [6:0] max_gain_half_db, // Gain cap in 0.5 dB.
	output logic hyst_on, // Hysteresis active.
	output logic [2:0] hyst_db, // Hysteresis in dB.
	output logic noise_det_on, // Noise detection active.
	output logic [7:0] noise_thr_neg_db, // Threshold magnitude in dB.
	output logic clip_step_on // Clip stepping active.
);
	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] ctrl_c;
		logic [7:0] lgain;
		logic times_ok;
	} agcr_state_t;
	agcr_state_t st_q, st_d;
	agcr_cfg_if cfg_bus ();
	logic addr_ok;
	logic req;
	logic [7:0] idx;
	logic [7:0] rd_val;
	// ------------------------------------------------------------
	// Address phase decode
	// ------------------------------------------------------------
	// Printed offsets 1d to 1f are not word multiples, so each offset is an index and the
	// byte address is four times it.
	assign idx = haddr[9:2];
	assign req = hsel && hready && htrans[1];
	assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
	always_comb begin
		rd_val = 8'h00;
		case (idx)
			`AGCR_IDX_CTRL_A: rd_val = st_q.ctrl_a;
			`AGCR_IDX_CTRL_B: rd_val = st_q.ctrl_b;
			`AGCR_IDX_CTRL_C: rd_val = st_q.ctrl_c;
			`AGCR_IDX_LGAIN: rd_val = st_q.lgain; // see RQ11
			default: rd_val = 8'h00;
		endcase
	end
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.wr_pend = 1'b0;
		// The gain readback tracks the algorithm every cycle; software cannot
		// write it. see RQ11
		st_d.lgain = left_gain_in;
		st_d.times_ok = !dbl_rate_on; // see RQ5
		if (st_q.wr_pend) begin
			case (st_q.wr_idx)
				`AGCR_IDX_CTRL_A: st_d.ctrl_a = hwdata[7:0];
				// The reserved bit is stored as written; keeping it clear
				// is up to software. see RQ7
				`AGCR_IDX_CTRL_B: st_d.ctrl_b = hwdata[7:0];
				`AGCR_IDX_CTRL_C: st_d.ctrl_c = hwdata[7:0];
				default: st_d.ctrl_a = st_q.ctrl_a;
			endcase
		end
		if (req && addr_ok) begin
			if (hwrite) begin
				st_d.wr_pend = 1'b1;
				st_d.wr_idx = idx;
			end else begin
				st_d.rdata = {24'h0, rd_val};
			end
		end else if (req) begin
			st_d.rdata = 32'h0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q.wr_pend <= 1'b0;
			st_q.wr_idx <= 8'h00;
			st_q.rdata <= 32'h0;
			st_q.ctrl_a <= `AGCR_RST_CTRL_A;
			st_q.ctrl_b <= `AGCR_RST_CTRL_B;
			st_q.ctrl_c <= `AGCR_RST_CTRL_C;
			st_q.lgain <= `AGCR_RST_LGAIN;
			st_q.times_ok <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end
	// ------------------------------------------------------------
	// Field split
	// ------------------------------------------------------------
	assign cfg_bus.cfg.enable = st_q.ctrl_a[`AGCR_BIT_EN]; // see RQ1
	assign cfg_bus.cfg.target = st_q.ctrl_a[`AGCR_TGT_HI:`AGCR_TGT_LO];
	assign cfg_bus.cfg.attack = st_q.ctrl_a[`AGCR_ATK_HI:`AGCR_ATK_LO];
	assign cfg_bus.cfg.decay = st_q.ctrl_a[`AGCR_DCY_HI:`AGCR_DCY_LO];
	assign cfg_bus.cfg.max_gain = st_q.ctrl_b[`AGCR_MAXG_HI:`AGCR_MAXG_LO];
	assign cfg_bus.cfg.hyst = st_q.ctrl_c[`AGCR_HYS_HI:`AGCR_HYS_LO];
	assign cfg_bus.cfg.noise_thr = st_q.ctrl_c[`AGCR_THR_HI:`AGCR_THR_LO];
	assign cfg_bus.cfg.clip_step = st_q.ctrl_c[`AGCR_BIT_CLIP]; // see RQ10
	agcr_decode u_decode (
		.hclk(hclk),
		.hresetn(hresetn),
		.cfg_in(cfg_bus.dst),
		.agc_on(agc_on),
		.target_code(target_code),
		.attack_ms(attack_ms),
		.decay_ms(decay_ms),
		.max_gain_half_db(max_gain_half_db),
		.hyst_on(hyst_on),
		.hyst_db(hyst_db),
		.noise_det_on(noise_det_on),
		.noise_thr_neg_db(noise_thr_neg_db),
		.clip_step_on(clip_step_on)
	);
	assign hrdata = st_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign times_valid = st_q.times_ok;
endmodule

//--- agcr_top_asserts.sv
// Port checker for the gain control register bank.
`timescale 1ns/100ps
`include "agcr_regs.svh"
module agcr_top_asserts (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset.
	input wire logic hsel, // Select.
	input wire logic [31:0] haddr, // Address.
	input wire logic [1:0] htrans, // Type.
	input wire logic hwrite, // Write.
	input wire logic [31:0] hwdata, // Data in.
	input wire logic hready, // Ready.
	input wire logic [31:0] hrdata, // Data out.
	input wire logic [7:0] left_gain_in, // Gain.
	input wire logic dbl_rate_on, // Rate.
	input wire logic agc_on, // Enable.
	input wire logic [2:0] target_code, // Target.
	input wire logic [15:0] attack_ms, // Attack.
	input wire logic [15:0] decay_ms, // Decay.
	input wire logic times_valid, // Exact.
	input wire logic [6:0] max_gain_half_db, // Cap.
	input wire logic hyst_on, // Hysteresis.
	input wire logic [7:0] noise_thr_neg_db, // Threshold.
	input wire logic clip_step_on // Clip.
);
	localparam logic [15:0] ATK [4] = '{16'd8, 16'd11, 16'd16, 16'd20};
	localparam logic [15:0] DCY [4] = '{16'd100, 16'd200, 16'd400, 16'd500};
	logic tk;
	logic w_q;
	logic r_q;
	logic [7:0] i_q;
	// Only word-aligned transfers in the first kilobyte are decoded, of any size.
	assign tk = hsel && hready && htrans[1] && haddr[31:10] == 22'h0 &&
		haddr[1:0] == 2'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w_q <= 1'b0;
			r_q <= 1'b0;
			i_q <= 8'h00;
		end else begin
			w_q <= tk && hwrite;
			r_q <= tk && !hwrite;
			i_q <= haddr[9:2];
		end
	end
	logic wa;
	logic wb;
	logic wc;
	assign wa = w_q && i_q == `AGCR_IDX_CTRL_A;
	assign wb = w_q && i_q == `AGCR_IDX_CTRL_B;
	assign wc = w_q && i_q == `AGCR_IDX_CTRL_C;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A register takes its data at the end of the data phase and the decoded
	// outputs follow one edge later, so each write check looks two edges ahead.
	a_enable_bit: assert property (
		wa |-> ##2 agc_on == $past(hwdata[7], 2))
		else $error("enable wrong");
	a_target_code: assert property (
		wa |-> ##2 target_code == $past(hwdata[6:4], 2))
		else $error("target wrong");
	a_attack_time: assert property (
		wa |-> ##2 attack_ms == ATK[$past(hwdata[3:2], 2)])
		else $error("attack wrong");
	a_decay_time: assert property (
		wa |-> ##2 decay_ms == DCY[$past(hwdata[1:0], 2)])
		else $error("decay wrong");
	a_times_exact: assert property (
		times_valid == !$past(dbl_rate_on)) else $error("times flag wrong");
	a_gain_cap: assert property (
		wb |-> ##2 max_gain_half_db == ($past(hwdata[7:1], 2) > 7'h77 ?
		7'h77 : $past(hwdata[7:1], 2))) else $error("gain cap wrong");
	a_hyst_off: assert property (
		wc |-> ##2 hyst_on == ($past(hwdata[7:6], 2) != 2'h3))
		else $error("hyst wrong");
	a_noise_level: assert property (
		wc && hwdata[5:1] != 5'h0 |-> ##2 noise_thr_neg_db ==
		8'd28 + {2'h0, $past(hwdata[5:1], 2), 1'b0})
		else $error("thr wrong");
	a_clip_step: assert property (
		wc |-> ##2 clip_step_on == $past(hwdata[0], 2))
		else $error("clip wrong");
	// The readback register lags the pin by one edge and the read data by
	// one more, so the data phase shows the gain of two edges before.
	a_gain_read: assert property (
		r_q && i_q == `AGCR_IDX_LGAIN |-> hrdata ==
		{24'h0, $past(left_gain_in, 2)}) else $error("gain read wrong");
endmodule
bind agcr_top agcr_top_asserts u_chk (.*);

//--- agcr_top_tb.sv
// Self-checking bench for the gain control register bank.
`timescale 1ns/100ps
module agcr_top_tb;
	import agcr_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic dbl_rate_on = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] left_gain_in = 8'he8;
	logic [31:0] hrdata, rd;
	logic [2:0] target_code, hyst_db;
	logic [15:0] attack_ms, decay_ms;
	logic [6:0] max_gain_half_db;
	logic [7:0] noise_thr_neg_db;
	logic hreadyout, hresp, agc_on, times_valid, hyst_on;
	logic noise_det_on, clip_step_on;
	wire hready = hreadyout;
	int bad_count = 0;
	int n_checks = 0;
	agcr_top dut (.*);
	always #50 hclk = ~hclk;
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// Outputs are read right at the edge, before the design's registers
	// update, so each value seen is the one the design presents there.
	task automatic step();
		do begin
			@(posedge hclk);
		end while (hready !== 1'b1);
	endtask
	task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		step();
		htrans <= 2'h0;
		hsel <= 1'b0;
		if (w) hwdata <= d;
		step();
		rd = hrdata;
	endtask
	task automatic rchk(string nm, logic [31:0] a, logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk("hresp", 32'h0, hresp);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge hclk);
		bad_count++;
		stop_test();
	end
	initial begin
		logic [7:0] v;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("attack", 32'd8, attack_ms);
		chk("decay", 32'd100, decay_ms);
		chk("maxg", 32'h77, max_gain_half_db);
		chk("hyst", 32'h1, hyst_on);
		rchk("reg_a", 32'h74, 32'h0);
		rchk("reg_b", 32'h78, 32'hfe);
		rchk("reg_c", 32'h7c, 32'h0);
		rchk("gain", 32'h80, 32'he8);
		for (int i = 0; i < 8; i++) begin
			v = {i[0], i[2:0], i[1:0], ~i[1:0]};
			xfer(1'b1, 32'h74, {24'h0, v});
			rchk("reg_a", 32'h74, {24'h0, v});
			chk("target", i, target_code);
			chk("enable", i[0], agc_on);
		end
		chk("attack", 32'd20, attack_ms);
		for (int i = 0; i < 3; i++) begin
			v = i == 0 ? 8'h00 : (i == 1 ? 8'hee : 8'hf0);
			xfer(1'b1, 32'h78, {24'h0, v});
			repeat (2) @(posedge hclk);
			chk("maxg", i == 0 ? 0 : 32'h77, max_gain_half_db);
		end
		for (int i = 0; i < 4; i++) begin
			v = {i[1:0], i == 3 ? 5'h1f : i[4:0], i[0]};
			xfer(1'b1, 32'h7c, {24'h0, v});
			repeat (2) @(posedge hclk);
			chk("hyst_db", i == 3 ? 0 : 1 << i, hyst_db);
			chk("hyst_on", i != 3, hyst_on);
			chk("noise_on", i != 0, noise_det_on);
			chk("thr", i == 3 ? 90 : (i ? 28 + 2 * i : 0),
				noise_thr_neg_db);
			chk("clip", i[0], clip_step_on);
		end
		xfer(1'b1, 32'h80, 32'h55);
		rchk("gain_ro", 32'h80, 32'he8);
		xfer(1'b1, 32'h70, 32'hff);
		rchk("reg_a", 32'h74, 32'hfc);
		rchk("unmapped", 32'h84, 32'h0);
		left_gain_in <= 8'h77;
		dbl_rate_on <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("tvalid", 32'h0, times_valid);
		dbl_rate_on <= 1'b0;
		rchk("gain", 32'h80, 32'h77);
		chk("tvalid", 32'h1, times_valid);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("reg_a", 32'h74, 32'h0);
		rchk("reg_b", 32'h78, 32'hfe);
		chk("maxg", 32'h77, max_gain_half_db);
		stop_test();
	end
endmodule
